// ===== shared/watch_timer_pkg.sv
`default_nettype none
package watch_timer_pkg;
  localparam logic [31:0] ctrl_wr_addr      = 32'hffff8610;
  localparam logic [31:0] ctrl_rd_addr      = 32'hffff8610;
  localparam logic [31:0] count_rd_addr     = 32'hffff8611;
  localparam logic [31:0] rstctl_wr_addr    = 32'hffff8612;
  localparam logic [31:0] rstctl_rd_addr    = 32'hffff8613;
  localparam logic [7:0]  key_count         = 8'h5a;
  localparam logic [7:0]  key_control       = 8'ha5;
  localparam logic [7:0]  count_reset       = 8'h00;
  localparam logic [7:0]  rstctl_reset      = 8'h1f;
  localparam logic [7:0]  flag_clear_data   = 8'h00;
  localparam logic [1:0]  ctrl_ones         = 2'h3;
  localparam logic [4:0]  rstctl_ones       = 5'h1f;
  localparam logic [2:0]  clock_sel_reset   = 3'h0;
  localparam int          flag_bit          = 7;
  localparam int          mode_bit          = 6;
  localparam int          enable_bit        = 5;
  localparam int          reset_enable_bit  = 6;
  localparam int          reset_type_bit    = 5;
  localparam int          prescale_width    = 13;
  localparam int          overflow_cycles   = 128;
  localparam int          chip_reset_cycles = 512;
  localparam int          pulse_width       = 10;
endpackage
`default_nettype wire

// ===== rtl/watch_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module watch_prescaler (
  input  wire logic       clk,
  input  wire logic       clear,
  input  wire logic [2:0] clock_divider_select,
  output logic            tick
);
  logic [watch_timer_pkg::prescale_width-1:0] div_reg;
  logic [watch_timer_pkg::prescale_width-1:0] mask;

  // The divider keeps running while the count is stopped, so changing the tap on the fly can give a short period.
  always_comb begin
    unique case (clock_divider_select)
      3'h0: mask = 13'h0001;
      3'h1: mask = 13'h003f;
      3'h2: mask = 13'h007f;
      3'h3: mask = 13'h00ff;
      3'h4: mask = 13'h01ff;
      3'h5: mask = 13'h03ff;
      3'h6: mask = 13'h0fff;
      3'h7: mask = 13'h1fff;
    endcase
  end

  assign tick = ((div_reg & mask) == mask); // [R11]

  always_ff @(posedge clk) begin
    if (clear) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 13'h0001;
    end
  end
endmodule // watch_prescaler
`default_nettype wire

// ===== rtl/watch_pulse_stretch.sv
`timescale 1ns/100ps
`default_nettype none
module watch_pulse_stretch #(
  parameter int cycles = watch_timer_pkg::overflow_cycles
) (
  input  wire logic clk,
  input  wire logic clear,
  input  wire logic start,
  output logic      active
);
  logic [watch_timer_pkg::pulse_width-1:0] left_reg;

  assign active = (left_reg != '0);

  always_ff @(posedge clk) begin
    if (clear) begin
      left_reg <= '0;
    end else if (start) begin
      left_reg <= (watch_timer_pkg::pulse_width)'(cycles);
    end else if (active) begin
      left_reg <= left_reg - 10'h001;
    end
  end
endmodule // watch_pulse_stretch
`default_nettype wire

// ===== rtl/watch_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1 - Eight-bit readable writable up-counter counts selected clock taps while enabled.
// R2 - Counter wrap from ff to 00 raises overflow output or interval interrupt.
// R3 - Counter clears on power-on and when enable written 0; standby keeps it. Here standby clears enable, which zeroes the counter.
// R4 - External manual reset spares counter and control; watchdog manual reset clears them.
// R5 - Flag, mode, enable clear on power-on and standby; clock select survives standby.
// R6 - Interval flag sets on wrap in interval mode only.
// R7 - Interval flag clears by reading 1 then writing 0; only 0 writes act.
// R8 - Mode bit 0 gives interval interrupts, 1 gives watchdog overflow output.
// R9 - Enable 0 stops and holds counter at zero; 1 starts counting.
// R10 - Control bits 4 and 3 read as 1.
// R11 - Clock select codes pick divide by 2,64,128,256,512,1024,4096,8192.
// R12 - Reset control loads 1f on pin reset and standby, keeps on watchdog reset.
// R13 - Watchdog flag sets on watchdog-mode wrap; cleared by read 1 then write 0.
// R14 - Reset enable 0 resets only counter and control; 1 also resets chip.
// R15 - Reset type 0 requests power-on reset, 1 requests manual reset.
// R16 - Counter and control take word writes only; byte writes ignored.
// R17 - Shared write address: key 5a loads counter, key a5 loads control.
// R18 - Reset control written only by word write at its own address.
// R19 - Word a500 to reset control clears only the watchdog flag.
// R20 - Key 5a to reset control copies bits 6 and 5 only.
// R21 - Overflow output asserts for exactly 128 clock cycles on watchdog wrap.
// R22 - Chip reset request lasts 512 cycles, starting with the overflow output.
// R23 - All three registers read by byte, each at its own address.
// R24 - A counter write in the same cycle as an increment wins.
// R25 - Overflow output is active low and idles high.
module watch_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        external_reset_n,
  input  wire logic        external_manual_reset_n,
  input  wire logic        standby,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  input  wire logic        bus_word,
  input  wire logic [15:0] bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             overflow_out_n,
  output logic             interval_irq,
  output logic             chip_reset_power_on,
  output logic             chip_reset_manual
);
  logic [7:0] watchdog_count_reg;
  logic [7:0] watchdog_count_next;
  logic       interval_overflow_flag_reg;
  logic       mode_select_reg;
  logic       count_enable_reg;
  logic [2:0] clock_divider_select_reg;
  logic       watchdog_overflow_flag_reg;
  logic       chip_reset_enable_reg;
  logic       chip_reset_type_reg;
  logic       ovf_seen_reg;
  logic       watchdog_overflow_flag_seen_reg;
  logic       reset_type_latch_reg;
  logic [7:0] bus_rdata_reg;
  logic       ext_rst_meta_reg;
  logic       ext_rst_sync_reg;
  logic       sb_meta_reg;
  logic       sb_sync_reg;

  // External reset and standby pins are double registered; external manual reset is deliberately unused here.
  always_ff @(posedge clk) begin
    ext_rst_meta_reg <= external_reset_n;
    ext_rst_sync_reg <= ext_rst_meta_reg;
    sb_meta_reg      <= standby;
    sb_sync_reg      <= sb_meta_reg;
  end

  wire pin_reset   = !reset_n || !ext_rst_sync_reg;
  wire standby_now = sb_sync_reg;

  wire tick;
  wire overflow_active;
  wire chip_reset_active;

  wire wr_word      = bus_write && bus_word; // [R16] [R18]
  wire key_is_count = (bus_wdata[15:8] == watch_timer_pkg::key_count);
  wire key_is_ctrl  = (bus_wdata[15:8] == watch_timer_pkg::key_control);
  wire wr_shared    = wr_word && (bus_addr == watch_timer_pkg::ctrl_wr_addr);
  wire wr_count     = wr_shared && key_is_count; // [R17]
  wire wr_ctrl      = wr_shared && key_is_ctrl; // [R17]
  wire wr_rst       = wr_word && (bus_addr == watch_timer_pkg::rstctl_wr_addr);
  wire wr_rst_bits  = wr_rst && key_is_count; // [R20]
  wire wr_rst_clear = wr_rst && key_is_ctrl && (bus_wdata[7:0] == watch_timer_pkg::flag_clear_data); // [R19]

  wire rd_byte  = bus_read && !bus_word; // [R23]
  wire rd_ctrl  = rd_byte && (bus_addr == watch_timer_pkg::ctrl_rd_addr);
  wire rd_count = rd_byte && (bus_addr == watch_timer_pkg::count_rd_addr);
  wire rd_rst   = rd_byte && (bus_addr == watch_timer_pkg::rstctl_rd_addr);

  wire step     = count_enable_reg && tick; // [R1]
  wire wrap     = step && !wr_count && (watchdog_count_reg == 8'hff); // [R2]
  wire wd_wrap  = wrap && mode_select_reg; // [R8]
  wire int_wrap = wrap && !mode_select_reg; // [R8]

  // Watchdog-generated reset of counter and control happens even with chip reset disabled.
  wire wd_clear = wd_wrap; // [R14] [R4]

  wire [7:0] ctrl_view = {interval_overflow_flag_reg, mode_select_reg, count_enable_reg,
                          watch_timer_pkg::ctrl_ones, clock_divider_select_reg}; // [R10]
  wire [7:0] rst_view  = {watchdog_overflow_flag_reg, chip_reset_enable_reg, chip_reset_type_reg,
                          watch_timer_pkg::rstctl_ones};

  wire       ctrl_to_zero = wr_ctrl && !bus_wdata[watch_timer_pkg::enable_bit];
  wire       ovf_clear    = wr_ctrl && ovf_seen_reg && !bus_wdata[watch_timer_pkg::flag_bit]; // [R7]
  wire       watchdog_overflow_flag_clear   = wr_rst_clear && watchdog_overflow_flag_seen_reg; // [R13]

  watch_prescaler prescaler_inst (
    .clk                  (clk),
    .clear                (pin_reset),
    .clock_divider_select (clock_divider_select_reg),
    .tick                 (tick)
  );

  watch_pulse_stretch #(
    .cycles (watch_timer_pkg::overflow_cycles)
  ) overflow_pulse_inst (
    .clk    (clk),
    .clear  (pin_reset),
    .start  (wd_wrap),
    .active (overflow_active)
  );

  watch_pulse_stretch #(
    .cycles (watch_timer_pkg::chip_reset_cycles)
  ) chip_reset_pulse_inst (
    .clk    (clk),
    .clear  (pin_reset),
    .start  (wd_wrap && chip_reset_enable_reg), // [R22]
    .active (chip_reset_active)
  );

  always_comb begin
    watchdog_count_next = watchdog_count_reg;
    if (wr_count) begin
      watchdog_count_next = bus_wdata[7:0]; // [R24]
    end else if (step) begin
      watchdog_count_next = watchdog_count_reg + 8'h01; // [R1]
    end
    if (!count_enable_reg || ctrl_to_zero || wd_clear) begin
      watchdog_count_next = watch_timer_pkg::count_reset; // [R3] [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || wd_clear) begin
      watchdog_count_reg <= watch_timer_pkg::count_reset; // [R3] [R4]
    end else begin
      watchdog_count_reg <= watchdog_count_next; // [R3]
    end
  end

  // Standby clears the run fields but not the clock select, so recovery counts at the rate chosen before.
  wire ctrl_hard_clear = !reset_n || wd_clear; // [R4]
  wire ctrl_run_clear  = ctrl_hard_clear || standby_now; // [R5]
  wire rst_ctl_clear   = pin_reset || standby_now; // [R12]

  // The set of the flag outranks a software clear in the same cycle, so no wrap is lost to a clearing write.
  always_ff @(posedge clk) begin
    if (ctrl_run_clear) begin
      interval_overflow_flag_reg <= 1'b0; // [R5]
    end else if (int_wrap) begin
      interval_overflow_flag_reg <= 1'b1; // [R6]
    end else if (ovf_clear) begin
      interval_overflow_flag_reg <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (ctrl_run_clear) begin
      mode_select_reg  <= 1'b0; // [R5]
      count_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      mode_select_reg  <= bus_wdata[watch_timer_pkg::mode_bit]; // [R8]
      count_enable_reg <= bus_wdata[watch_timer_pkg::enable_bit]; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (ctrl_hard_clear) begin
      clock_divider_select_reg <= watch_timer_pkg::clock_sel_reset; // [R5]
    end else if (wr_ctrl && !standby_now) begin
      clock_divider_select_reg <= bus_wdata[2:0]; // [R11]
    end
  end

  // Reset control survives the watchdog's own reset, so software can still see why the chip restarted.
  always_ff @(posedge clk) begin
    if (rst_ctl_clear) begin
      watchdog_overflow_flag_reg <= watch_timer_pkg::rstctl_reset[7]; // [R12]
    end else if (wd_wrap) begin
      watchdog_overflow_flag_reg <= 1'b1; // [R13]
    end else if (watchdog_overflow_flag_clear) begin
      watchdog_overflow_flag_reg <= 1'b0; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (rst_ctl_clear) begin
      chip_reset_enable_reg <= watch_timer_pkg::rstctl_reset[6]; // [R12]
      chip_reset_type_reg   <= watch_timer_pkg::rstctl_reset[5];
    end else if (wr_rst_bits) begin
      chip_reset_enable_reg <= bus_wdata[watch_timer_pkg::reset_enable_bit]; // [R20]
      chip_reset_type_reg   <= bus_wdata[watch_timer_pkg::reset_type_bit];
    end
  end

  // A flag read as 1 arms the clear; a write attempt disarms it, so a blind write of 0 never clears.
  always_ff @(posedge clk) begin
    if (pin_reset) begin
      ovf_seen_reg <= 1'b0;
    end else if (rd_ctrl) begin
      ovf_seen_reg <= interval_overflow_flag_reg; // [R7]
    end else if (wr_ctrl) begin
      ovf_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (pin_reset) begin
      watchdog_overflow_flag_seen_reg <= 1'b0;
    end else if (rd_rst) begin
      watchdog_overflow_flag_seen_reg <= watchdog_overflow_flag_reg; // [R13]
    end else if (wr_rst_clear) begin
      watchdog_overflow_flag_seen_reg <= 1'b0;
    end
  end

  // The reset type is frozen at the wrap so a later write cannot change a pulse in flight.
  always_ff @(posedge clk) begin
    if (pin_reset) begin
      reset_type_latch_reg <= 1'b0;
    end else if (wd_wrap) begin
      reset_type_latch_reg <= chip_reset_type_reg; // [R15]
    end
  end

  // Word reads and unmapped addresses return zero rather than stale data.
  wire [7:0] rdata_next = rd_ctrl  ? ctrl_view :
                          rd_count ? watchdog_count_reg :
                          rd_rst   ? rst_view :
                          8'h00; // [R23]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata_reg <= 8'h00;
    end else begin
      bus_rdata_reg <= rdata_next; // [R23]
    end
  end

  assign bus_rdata           = bus_rdata_reg;
  assign overflow_out_n      = !overflow_active; // [R21] [R25]
  assign interval_irq        = interval_overflow_flag_reg; // [R2]
  assign chip_reset_power_on = chip_reset_active && !reset_type_latch_reg; // [R14] [R15]
  assign chip_reset_manual   = chip_reset_active && reset_type_latch_reg; // [R15]
endmodule // watch_timer
`default_nettype wire

// ===== verif/watch_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module watch_timer_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_read,
  input wire logic        bus_word,
  input wire logic [7:0]  bus_rdata,
  input wire logic        overflow_out_n,
  input wire logic        interval_irq,
  input wire logic        chip_reset_power_on,
  input wire logic        chip_reset_manual
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] low_cnt;
  logic [9:0] rst_cnt;
  logic       chip_rst;
  logic       rd_ctl;
  logic       rd_rst;
  assign chip_rst = chip_reset_power_on | chip_reset_manual;
  assign rd_ctl = bus_read && !bus_word && bus_addr == watch_timer_pkg::ctrl_rd_addr;
  assign rd_rst = bus_read && !bus_word && bus_addr == watch_timer_pkg::rstctl_rd_addr;
  // Pulse lengths are counted here, since a repetition of 128 or 512 would be unrolled by the tools.
  always_ff @(posedge clk) begin
    low_cnt <= overflow_out_n ? 10'h000 : low_cnt + 10'h001;
    rst_cnt <= chip_rst ? rst_cnt + 10'h001 : 10'h000;
  end
  a_ovf_width: assert property ($rose(overflow_out_n) |-> low_cnt == 10'h080)
    else $error("overflow pulse length wrong");
  a_ovf_ends: assert property ($fell(overflow_out_n) |-> ##128 overflow_out_n)
    else $error("overflow pulse not over after 128 cycles");
  a_rst_width: assert property ($fell(chip_rst) |-> rst_cnt == 10'h200)
    else $error("chip reset length wrong");
  a_rst_start: assert property ($rose(chip_rst) |-> $fell(overflow_out_n))
    else $error("chip reset did not start with overflow output");
  a_rst_type: assert property (!(chip_reset_power_on && chip_reset_manual))
    else $error("both chip reset types active");
  a_wdog_no_irq: assert property ($fell(overflow_out_n) |-> !$rose(interval_irq))
    else $error("interval flag set by watchdog wrap");
  a_irq_no_ovf: assert property ($rose(interval_irq) |-> overflow_out_n && !chip_rst)
    else $error("interval wrap drove watchdog outputs");
  a_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == 8'h00)
    else $error("read data not idle");
  a_ctrl_ones: assert property ($past(rd_ctl) |-> bus_rdata[4:3] == 2'h3)
    else $error("control reserved bits not one");
  a_rstctl_ones: assert property ($past(rd_rst) |-> bus_rdata[4:0] == 5'h1f)
    else $error("reset control reserved bits not one");
endmodule // watch_timer_chk
bind watch_timer watch_timer_chk u_chk (.*);
`default_nettype wire

// ===== verif/watch_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module watch_bus_master (
  input  wire logic        clk,
  output logic      [31:0] bus_addr,
  output logic             bus_write,
  output logic             bus_read,
  output logic             bus_word,
  output logic      [15:0] bus_wdata
);
  initial {bus_addr, bus_write, bus_read, bus_word, bus_wdata} = '0;
  // Address and data are inverted on release so a stale bus never looks like a live one.
  task automatic xfer(input logic [31:0] a, input logic [15:0] d, input logic w, input logic rd);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_word  <= w;
    bus_write <= !rd;
    bus_read  <= rd;
    @(posedge clk);
    bus_write <= 1'b0;
    bus_read  <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask
endmodule // watch_bus_master
`default_nettype wire

// ===== verif/watch_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, g, e); end end
module watch_timer_test;
  localparam logic [31:0] ctl_w = watch_timer_pkg::ctrl_wr_addr;
  localparam logic [31:0] rst_w = watch_timer_pkg::rstctl_wr_addr;
  localparam logic [31:0] ctl_r = watch_timer_pkg::ctrl_rd_addr;
  localparam logic [31:0] cnt_r = watch_timer_pkg::count_rd_addr;
  localparam logic [31:0] rst_r = watch_timer_pkg::rstctl_rd_addr;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        external_reset_n = 1'b0;
  logic        external_manual_reset_n = 1'b1;
  logic        standby = 1'b0;
  logic [31:0] bus_addr;
  logic        bus_write;
  logic        bus_read;
  logic        bus_word;
  logic [15:0] bus_wdata;
  logic [7:0]  bus_rdata;
  logic        overflow_out_n;
  logic        interval_irq;
  logic        chip_reset_power_on;
  logic        chip_reset_manual;
  logic [7:0]  expq[$];
  logic [7:0]  exp_v;
  logic        rd_d = 1'b0;
  logic [7:0]  rnd;
  int          divs[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;
  always #10 clk = ~clk;
  watch_bus_master u_cpu (.*);
  watch_timer dut (.*);
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    u_cpu.xfer(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_cpu.xfer(a, 16'h0000, 1'b0, 1'b1);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      exp_v = expq.pop_front();
      `CHK(bus_rdata, exp_v)
    end
    rd_d <= bus_read;
    cyc++;
    if (cyc == 80000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    rnd = 8'($urandom(32'hdc5fb6f4));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    external_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ctl_r, 8'h18);
    rd(cnt_r, 8'h00);
    rd(rst_r, 8'h1f);
    u_cpu.xfer(rst_w, 16'h5a60, 1'b0, 1'b0);
    rd(rst_r, 8'h1f);
    wr(ctl_w, 16'ha527);
    u_cpu.xfer(ctl_w, 16'h5a77, 1'b0, 1'b0);
    rd(cnt_r, 8'h00);
    wr(ctl_w, 16'h5a77);
    wr(ctl_w, 16'h3355);
    rd(cnt_r, 8'h77);
    wr(ctl_w, 16'ha500);
    rd(cnt_r, 8'h00);
    // Four prescaled periods always hold exactly four ticks, whatever the prescaler phase.
    for (int c = 0; c < 8; c++) begin
      wr(ctl_w, {8'ha5, 8'h20 | 8'(c)});
      repeat (4 * divs[c] - 1) @(posedge clk);
      rd(cnt_r, 8'h04);
      wr(ctl_w, 16'ha500);
    end
    wr(ctl_w, 16'ha520);
    wr(ctl_w, 16'h5afc);
    n = 0;
    while (interval_irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(interval_irq, 1'b1)
    wr(ctl_w, 16'ha520);
    @(negedge clk);
    `CHK(interval_irq, 1'b1)
    rd(ctl_r, 8'hb8);
    wr(ctl_w, 16'ha520);
    @(negedge clk);
    `CHK(interval_irq, 1'b0)
    for (int t = 0; t < 2; t++) begin
      wr(ctl_w, 16'ha500);
      wr(rst_w, {8'h5a, 1'b0, 1'b1, t[0], 5'h00});
      wr(ctl_w, 16'ha560);
      wr(ctl_w, 16'h5afe);
      n = 0;
      while (overflow_out_n !== 1'b0 && n < 40) begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (overflow_out_n === 1'b0 && n < 300) begin
        @(posedge clk);
        n++;
      end
      `CHK(n, 128)
      `CHK(chip_reset_manual, t[0])
      `CHK(chip_reset_power_on, !t[0])
      while ((chip_reset_manual || chip_reset_power_on) === 1'b1 && n < 600) begin
        @(posedge clk);
        n++;
      end
      `CHK(n, 512)
      rd(ctl_r, 8'h18);
      rd(cnt_r, 8'h00);
      rd(rst_r, {2'b11, t[0], 5'h1f});
      wr(rst_w, 16'ha500);
      rd(rst_r, {2'b01, t[0], 5'h1f});
    end
    repeat (4) begin
      rnd = 8'($urandom);
      wr(rst_w, {8'h5a, rnd});
      rd(rst_r, {1'b0, rnd[6:5], 5'h1f});
    end
    external_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    external_reset_n <= 1'b1;
    rd(rst_r, 8'h1f);
    wr(rst_w, 16'h5a60);
    wr(ctl_w, 16'ha567);
    external_manual_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    external_manual_reset_n <= 1'b1;
    rd(ctl_r, 8'h7f);
    standby <= 1'b1;
    repeat (6) @(posedge clk);
    standby <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ctl_r, 8'h1f);
    rd(rst_r, 8'h1f);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule // watch_timer_test
`default_nettype wire
